// [ulpx_pkg.sv]
package ulpx_pkg;

   // Register offsets on the AHB-Lite bus, one aligned word each.
   localparam logic [7:0] ULPX_OFS_CMD    = 8'h00;
   localparam logic [7:0] ULPX_OFS_TXDATA = 8'h04;
   localparam logic [7:0] ULPX_OFS_STATUS = 8'h08;
   localparam logic [7:0] ULPX_OFS_RXCMD  = 8'h0C;

   // Command register fields.
   localparam int ULPX_CMD_KIND_LSB = 0;
   localparam int ULPX_CMD_ADDR_LSB = 8;
   localparam int ULPX_CMD_PID_LSB  = 16;

   // Transmit data register fields.
   localparam int ULPX_TX_BYTE_LSB = 0;
   localparam int ULPX_TX_LAST_BIT = 8;
   localparam int ULPX_TX_FULL_BIT = 9;

   // Status register fields.
   localparam int ULPX_ST_BUSY_BIT  = 0;
   localparam int ULPX_ST_DONE_BIT  = 1;
   localparam int ULPX_ST_ALT_BIT   = 2;
   localparam int ULPX_ST_DIR_BIT   = 3;
   localparam int ULPX_ST_ABORT_BIT = 4;
   localparam int ULPX_ST_RDAT_LSB  = 8;
   localparam int ULPX_ST_RXC_LSB   = 16;

   // Receive-command register fields.
   localparam int ULPX_RX_BYTE_LSB  = 0;
   localparam int ULPX_RX_COUNT_LSB = 8;

   // Transmit-command byte layout: two code bits above a six-bit payload.
   localparam logic [1:0] ULPX_CODE_IDLE   = 2'b00;
   localparam logic [1:0] ULPX_CODE_PACKET = 2'b01;
   localparam logic [1:0] ULPX_CODE_REGW   = 2'b10;
   localparam logic [1:0] ULPX_CODE_REGR   = 2'b11;
   localparam logic [5:0] ULPX_PAYLOAD_EXT = 6'h2F;
   localparam logic [7:0] ULPX_BUS_IDLE    = 8'h00;

   // Receive-command byte bit positions.
   localparam int ULPX_RXC_LINE_LSB = 0;
   localparam int ULPX_RXC_VBUS_LSB = 2;
   localparam int ULPX_RXC_EVT_LSB  = 4;
   localparam int ULPX_RXC_ID_BIT   = 6;
   localparam int ULPX_RXC_ALT_BIT  = 7;

   typedef enum logic [2:0] {
      ULPX_K_NOOP  = 3'b000,
      ULPX_K_NOPID = 3'b001,
      ULPX_K_PID   = 3'b010,
      ULPX_K_REGW  = 3'b011,
      ULPX_K_EXTW  = 3'b100,
      ULPX_K_REGR  = 3'b101,
      ULPX_K_EXTR  = 3'b110
   } ulpx_kind_t;

   typedef enum logic [2:0] {
      ULPX_S_IDLE  = 3'b000,
      ULPX_S_CMD   = 3'b001,
      ULPX_S_ADDR  = 3'b010,
      ULPX_S_WDATA = 3'b011,
      ULPX_S_TXDAT = 3'b100,
      ULPX_S_STOP  = 3'b101,
      ULPX_S_TURN  = 3'b110,
      ULPX_S_RDATA = 3'b111
   } ulpx_state_t;

endpackage

// [ulpx_sync.sv]
`timescale 1ns/1ps
module ulpx_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } ulpx_sync_t;

   ulpx_sync_t r;
   ulpx_sync_t next_r;

   always_comb begin
      next_r.meta = d;
      next_r.sync = r.meta;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign q = r.sync;
endmodule

// [ulpx_ahb.sv]
`timescale 1ns/1ps
module ulpx_ahb (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             wr_en,
   output logic      [7:0]  reg_addr,
   output logic      [31:0] wr_data,
   input  wire logic [31:0] rd_data
);
   typedef struct packed {
      logic        wr_pend;
      logic        rd_pend;
      logic        rd_done;
      logic [7:0]  addr;
      logic [31:0] rdata;
   } ulpx_ahb_t;

   ulpx_ahb_t r;
   ulpx_ahb_t next_r;
   logic      take;

   // Only whole-word transfers are issued, so hsize needs no decoding.
   assign take = hsel && htrans[1] && hready;

   always_comb begin
      next_r = r;
      next_r.wr_pend = 1'b0;
      next_r.rd_done = 1'b0;
      if (r.rd_pend) begin
         next_r.rd_pend = 1'b0;
         next_r.rd_done = 1'b1;
         next_r.rdata   = rd_data;
      end
      if (take) begin
         next_r.addr    = haddr[7:0];
         next_r.wr_pend = hwrite;
         next_r.rd_pend = !hwrite;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Reads insert one wait state so that hrdata comes from a flip-flop.
   assign hreadyout = !r.rd_pend;
   assign hrdata    = r.rdata;
   assign hresp     = 1'b0;
   assign wr_en     = r.wr_pend;
   assign reg_addr  = r.addr;
   assign wr_data   = hwdata;
endmodule

// [ulpx_link.sv]
// Operation
// - Drive all-zero bus whenever nothing to send.
// - Send nonzero command, await acceptance, then data.
// - Code 00 with zero payload is no-operation.
// - Code 01 zero payload sends signalling without PID.
// - Code 01 with low nibble sends PID packet.
// - Extended write sends 8-bit address before data.
// - Register write carries 6-bit immediate address.
// - Extended read sends 8-bit address after acceptance.
// - Register read carries 6-bit immediate address.
// - Never send a command outside defined set.
// - Accept status bytes at any moment, even mid-packet.
// - Never depend on status after low-power exit.
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module ulpx_link
   import ulpx_pkg::*;
#(
   // Width of the wrapping count of status bytes.
   parameter int CNT_W = 8
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        ulpi_dir,
   input  wire logic        ulpi_nxt,
   input  wire logic [7:0]  ulpi_data_in,
   output logic      [7:0]  ulpi_data_out,
   output logic             ulpi_data_oe,
   output logic             ulpi_stp,
   output logic      [1:0]  line_state,
   output logic      [1:0]  vbus_state,
   output logic      [1:0]  rx_event,
   output logic             id_level
);

   typedef struct packed {
      ulpx_state_t      state;
      ulpx_kind_t       kind;
      logic [7:0]       addr;
      logic [3:0]       pid;
      logic [7:0]       tx_byte;
      logic             tx_last;
      logic             tx_full;
      logic             done;
      logic             abort;
      logic             alternate_event_flag;
      logic [7:0]       rd_byte;
      logic [7:0]       rxcmd;
      logic [CNT_W-1:0] rx_count;
      logic             dir_prev;
      logic [7:0]       dout;
      logic             oe;
      logic             stp;
   } ulpx_link_t;

   ulpx_link_t r;
   ulpx_link_t next_r;

   logic        wr_en;
   logic [7:0]  reg_addr;
   logic [31:0] wr_data;
   logic [31:0] rd_data;
   logic [9:0]  pins_s;
   logic        dir_s;
   logic        nxt_s;
   logic [7:0]  din_s;
   logic        turn;
   logic        rx_take;

   ulpx_ahb u_ahb (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .wr_en     (wr_en),
      .reg_addr  (reg_addr),
      .wr_data   (wr_data),
      .rd_data   (rd_data)
   );

   ulpx_sync #(
      .W (10)
   ) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .d       ({ulpi_dir, ulpi_nxt, ulpi_data_in}),
      .q       (pins_s)
   );

   assign dir_s = pins_s[9];
   assign nxt_s = pins_s[8];
   assign din_s = pins_s[7:0];

   // A change of direction costs one turnaround cycle in which nobody drives.
   assign turn = dir_s != r.dir_prev;

   // Status bytes come while the device owns the bus with acceptance low.
   assign rx_take = dir_s && !turn && !nxt_s && (r.state != ULPX_S_RDATA);

   // Builds the transmit-command byte; only the defined encodings can leave.
   function automatic logic [7:0] ulpx_txcmd(input ulpx_kind_t k, input logic [7:0] a,
                                             input logic [3:0] p);
      logic [7:0] b;
      b = ULPX_BUS_IDLE;
      case (k)
         ULPX_K_NOPID: b = {ULPX_CODE_PACKET, 6'h00};
         ULPX_K_PID:   b = {ULPX_CODE_PACKET, 2'b00, p};
         ULPX_K_REGW:  b = {ULPX_CODE_REGW, a[5:0]};
         ULPX_K_EXTW:  b = {ULPX_CODE_REGW, ULPX_PAYLOAD_EXT};
         ULPX_K_REGR:  b = {ULPX_CODE_REGR, a[5:0]};
         ULPX_K_EXTR:  b = {ULPX_CODE_REGR, ULPX_PAYLOAD_EXT};
         default:      b = {ULPX_CODE_IDLE, 6'h00};
      endcase
      return b;
   endfunction

   // An immediate address of 6'h2F would alias the extended code, so it is refused.
   function automatic logic ulpx_legal(input ulpx_kind_t k, input logic [7:0] a);
      logic ok;
      ok = 1'b0;
      case (k)
         ULPX_K_NOOP, ULPX_K_NOPID, ULPX_K_PID, ULPX_K_EXTW, ULPX_K_EXTR: ok = 1'b1;
         ULPX_K_REGW, ULPX_K_REGR: ok = (a[5:0] != ULPX_PAYLOAD_EXT) && (a[7:6] == 2'b00);
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   always_comb begin
      rd_data = 32'h0000_0000;
      case (reg_addr)
         ULPX_OFS_CMD: begin
            rd_data[ULPX_CMD_KIND_LSB +: 3] = r.kind;
            rd_data[ULPX_CMD_ADDR_LSB +: 8] = r.addr;
            rd_data[ULPX_CMD_PID_LSB +: 4]  = r.pid;
         end
         ULPX_OFS_TXDATA: begin
            rd_data[ULPX_TX_BYTE_LSB +: 8] = r.tx_byte;
            rd_data[ULPX_TX_LAST_BIT]      = r.tx_last;
            rd_data[ULPX_TX_FULL_BIT]      = r.tx_full;
         end
         ULPX_OFS_STATUS: begin
            rd_data[ULPX_ST_BUSY_BIT]      = r.state != ULPX_S_IDLE;
            rd_data[ULPX_ST_DONE_BIT]      = r.done;
            rd_data[ULPX_ST_ALT_BIT]       = r.alternate_event_flag;
            // Direction is live so software sees a device holding the bus.
            rd_data[ULPX_ST_DIR_BIT]       = dir_s;
            rd_data[ULPX_ST_ABORT_BIT]     = r.abort;
            rd_data[ULPX_ST_RDAT_LSB +: 8] = r.rd_byte;
            rd_data[ULPX_ST_RXC_LSB +: 8]  = r.rxcmd;
         end
         ULPX_OFS_RXCMD: begin
            rd_data[ULPX_RX_BYTE_LSB +: 8]      = r.rxcmd;
            rd_data[ULPX_RX_COUNT_LSB +: CNT_W] = r.rx_count;
         end
         default: rd_data = 32'h0000_0000;
      endcase
   end

   always_comb begin
      next_r = r;
      next_r.dir_prev = dir_s;

      // Software writes; hardware sets below take precedence over clears.
      if (wr_en) begin
         case (reg_addr)
            ULPX_OFS_CMD: begin
               // A refused command leaves busy, done and abort as they were.
               if (r.state == ULPX_S_IDLE &&
                   ulpx_legal(ulpx_kind_t'(wr_data[ULPX_CMD_KIND_LSB +: 3]),
                              wr_data[ULPX_CMD_ADDR_LSB +: 8])) begin
                  next_r.kind  = ulpx_kind_t'(wr_data[ULPX_CMD_KIND_LSB +: 3]);
                  next_r.addr  = wr_data[ULPX_CMD_ADDR_LSB +: 8];
                  next_r.pid   = wr_data[ULPX_CMD_PID_LSB +: 4];
                  next_r.state = ULPX_S_CMD;
                  next_r.done  = 1'b0;
                  next_r.abort = 1'b0;
               end
            end
            ULPX_OFS_TXDATA: begin
               // A write to a full holding register is dropped.
               if (!r.tx_full) begin
                  next_r.tx_byte = wr_data[ULPX_TX_BYTE_LSB +: 8];
                  next_r.tx_last = wr_data[ULPX_TX_LAST_BIT];
                  next_r.tx_full = 1'b1;
               end
            end
            ULPX_OFS_STATUS: begin
               if (wr_data[ULPX_ST_DONE_BIT]) begin
                  next_r.done = 1'b0;
               end
               if (wr_data[ULPX_ST_ALT_BIT]) begin
                  next_r.alternate_event_flag = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      // Every status byte is taken into rxcmd and counted; nothing waits for one to arrive.
      if (rx_take) begin
         next_r.rxcmd    = din_s;
         // The count wraps; software takes differences between reads.
         next_r.rx_count = r.rx_count + 1'b1;
         if (din_s[ULPX_RXC_ALT_BIT]) begin
            next_r.alternate_event_flag = 1'b1;
         end
      end

      case (r.state)
         ULPX_S_IDLE: begin
         end
         ULPX_S_CMD: begin
            // A device that takes the bus first simply delays the command.
            if (r.kind == ULPX_K_NOOP) begin
               next_r.state = ULPX_S_IDLE;
               next_r.done  = 1'b1;
            end else if (!dir_s && !turn && nxt_s) begin
               case (r.kind)
                  ULPX_K_EXTW, ULPX_K_EXTR: next_r.state = ULPX_S_ADDR;
                  ULPX_K_REGW:              next_r.state = ULPX_S_WDATA;
                  ULPX_K_REGR:              next_r.state = ULPX_S_TURN;
                  default:                  next_r.state = ULPX_S_TXDAT;
               endcase
            end
         end
         ULPX_S_ADDR: begin
            // A device that takes the bus here ends the transfer.
            if (dir_s) begin
               next_r.state = ULPX_S_IDLE;
               next_r.abort = 1'b1;
               next_r.done  = 1'b1;
            end else if (nxt_s) begin
               next_r.state = (r.kind == ULPX_K_EXTW) ? ULPX_S_WDATA : ULPX_S_TURN;
            end
         end
         ULPX_S_WDATA: begin
            // The byte stands until the device accepts it.
            if (dir_s) begin
               next_r.state = ULPX_S_IDLE;
               next_r.abort = 1'b1;
               next_r.done  = 1'b1;
            end else if (nxt_s && r.tx_full) begin
               next_r.tx_full = 1'b0;
               next_r.state   = ULPX_S_STOP;
            end
         end
         ULPX_S_TXDAT: begin
            // The byte in the holding register is consumed on each acceptance.
            if (dir_s) begin
               next_r.state = ULPX_S_IDLE;
               next_r.abort = 1'b1;
               next_r.done  = 1'b1;
            end else if (nxt_s && r.tx_full) begin
               next_r.tx_full = 1'b0;
               if (r.tx_last) begin
                  next_r.state = ULPX_S_STOP;
               end
            end
         end
         ULPX_S_STOP: begin
            // Stop lasts one cycle with the idle byte on the bus.
            next_r.state = ULPX_S_IDLE;
            next_r.done  = 1'b1;
         end
         ULPX_S_TURN: begin
            // Acceptance at the turnaround means the read was pre-empted.
            if (dir_s && turn) begin
               next_r.state = nxt_s ? ULPX_S_IDLE : ULPX_S_RDATA;
               next_r.abort = nxt_s;
               next_r.done  = nxt_s;
            end
         end
         ULPX_S_RDATA: begin
            // The register byte follows the turnaround cycle directly.
            next_r.rd_byte = din_s;
            next_r.state   = ULPX_S_IDLE;
            next_r.done    = 1'b1;
         end
         default: next_r.state = ULPX_S_IDLE;
      endcase

      // Data and stop follow the next state, enable follows direction and turnaround, so that the pins come from flip-flops.
      next_r.oe  = !dir_s && !turn;
      next_r.stp = next_r.state == ULPX_S_STOP;
      case (next_r.state)
         ULPX_S_CMD:   next_r.dout = ulpx_txcmd(next_r.kind, next_r.addr, next_r.pid);
         ULPX_S_ADDR:  next_r.dout = next_r.addr;
         ULPX_S_WDATA: next_r.dout = next_r.tx_byte;
         ULPX_S_TXDAT: next_r.dout = next_r.tx_byte;
         default:      next_r.dout = ULPX_BUS_IDLE;
      endcase
   end

   // Reset leaves the bus idle and undriven.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign ulpi_data_out = r.dout;
   assign ulpi_data_oe  = r.oe;
   assign ulpi_stp      = r.stp;

   // Decoded status fields; meaning of line state depends on the selected mode.
   assign line_state = r.rxcmd[ULPX_RXC_LINE_LSB +: 2];
   assign vbus_state = r.rxcmd[ULPX_RXC_VBUS_LSB +: 2];
   assign rx_event   = r.rxcmd[ULPX_RXC_EVT_LSB +: 2];
   assign id_level   = r.rxcmd[ULPX_RXC_ID_BIT];

endmodule

// [ulpx_link_asserts.sv]
`timescale 1ns/1ps
module ulpx_link_asserts
   import ulpx_pkg::*;
#(
   parameter int CNT_W = 8
) (
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hwrite,
   input wire logic       hready,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic       ulpi_dir,
   input wire logic       ulpi_nxt,
   input wire logic [7:0] ulpi_data_in,
   input wire logic [7:0] ulpi_data_out,
   input wire logic       ulpi_data_oe,
   input wire logic       ulpi_stp,
   input wire logic [1:0] line_state,
   input wire logic [1:0] vbus_state,
   input wire logic [1:0] rx_event,
   input wire logic       id_level
);
   // Recent history of the device pins; the link sees them two flops late.
   logic [5:0] nh;
   logic [5:0] dh;
   logic [2:0] age;
   logic [6:0] fld;
   assign fld = {id_level, rx_event, vbus_state, line_state};
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         nh  <= 6'h00;
         dh  <= 6'h00;
         age <= 3'd0;
      end else begin
         nh  <= {nh[4:0], ulpi_nxt};
         dh  <= {dh[4:0], ulpi_dir};
         if (age != 3'd7) age <= age + 3'd1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence rd_take;
      hsel && htrans[1] && hready && !hwrite;
   endsequence
   sequence rd_ans;
      !hreadyout ##1 hreadyout;
   endsequence
   chk_read_wait: assert property (rd_take |=> rd_ans)
      else $error("read answer out of step");
   chk_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   chk_stp_idle: assert property (ulpi_stp |-> ulpi_data_out == ULPX_BUS_IDLE)
      else $error("stop without idle byte");
   chk_stp_single: assert property (ulpi_stp |=> !ulpi_stp)
      else $error("stop longer than one cycle");
   chk_stp_after_nxt: assert property ($rose(ulpi_stp) |-> nh != 6'h00)
      else $error("stop without acceptance");
   chk_cmd_legal: assert property (ulpi_data_oe && $past(ulpi_data_oe)
      && $past(ulpi_data_out) == 8'h00 && ulpi_data_out != 8'h00
      |-> ulpi_data_out[7:6] != 2'b00
      && !(ulpi_data_out[7:6] == 2'b01 && ulpi_data_out[5:4] != 2'b00))
      else $error("illegal command byte");
   chk_hold_byte: assert property ($past(ulpi_data_oe) && ulpi_data_oe
      && $past(ulpi_data_out) != 8'h00 && $changed(ulpi_data_out)
      |-> nh != 6'h00 || dh != 6'h00)
      else $error("byte dropped before acceptance");
   chk_release_dir: assert property (ulpi_dir[*2] |-> ##[1:3] !ulpi_data_oe)
      else $error("link kept driving under dir");
   chk_status_map: assert property (age == 3'd7 && $changed(fld)
      |-> fld == $past(ulpi_data_in[6:0], 3) || fld == $past(ulpi_data_in[6:0], 4))
      else $error("status fields not from bus");
endmodule

bind ulpx_link ulpx_link_asserts #(.CNT_W(CNT_W)) u_chk (.*);

// [ulpx_dev_model.sv]
`timescale 1ns/1ps
module ulpx_dev_model (
   input  wire logic       clk,
   input  wire logic [7:0] ulpi_data_out,
   input  wire logic       ulpi_data_oe,
   input  wire logic       ulpi_stp,
   input  wire logic [1:0] line,
   input  wire logic [1:0] vbus,
   input  wire logic [1:0] evt,
   input  wire logic       id_pin,
   input  wire logic       alt_ev,
   input  wire logic [2:0] lag,
   output logic            ulpi_dir,
   output logic            ulpi_nxt,
   output logic      [7:0] ulpi_data_in,
   output logic            got,
   output logic      [7:0] got_byte
);
   logic [7:0] rf [256];
   logic [7:0] sq [$];
   logic [7:0] oq [$];
   logic [7:0] held, cmd, adr, drv, last;
   logic       hold, rdp;
   int         n, wt;
   wire  [7:0] stat = {alt_ev, id_pin, evt, vbus, line};
   // An undriven bus shows the inverse of the last byte, never a stale copy.
   assign ulpi_data_in = ulpi_dir ? drv : (ulpi_data_oe ? ulpi_data_out : ~ulpi_data_out);
   initial begin
      for (int i = 0; i < 256; i++) rf[i] = 8'(i) ^ 8'h3C;
      {ulpi_dir, ulpi_nxt, got, hold, rdp} = 5'h00;
      {n, wt, last} = '0;
   end
   always @(posedge clk) begin
      got      <= 1'b0;
      ulpi_nxt <= 1'b0;
      last     <= stat;
      if (stat != last) sq.push_back(stat);
      if (ulpi_stp || (hold && ulpi_data_out != held)) hold <= 1'b0;
      if (ulpi_stp) n <= 0;
      if (ulpi_dir) begin
         if (oq.size() != 0) drv <= oq.pop_front();
         else ulpi_dir <= 1'b0;
      end else if (rdp || (sq.size() != 0 && n == 0 && !hold && ulpi_data_out == 8'h00)) begin
         ulpi_dir <= 1'b1;
         drv      <= 8'h5A;
         rdp      <= 1'b0;
         if (!rdp) begin
            oq = sq;
            sq = {};
         end
      end else if (!hold && ulpi_data_oe && ulpi_data_out != 8'h00 && !ulpi_stp) begin
         if (wt < lag) wt <= wt + 1;
         else begin
            {wt, ulpi_nxt, got, hold} <= {32'd0, 3'b111};
            got_byte <= ulpi_data_out;
            held     <= ulpi_data_out;
            n        <= n + 1;
            if (n == 0) cmd <= ulpi_data_out;
            if (n == 0 && ulpi_data_out[7:6] == 2'b11 && ulpi_data_out[5:0] != 6'h2F) begin
               oq.push_back(rf[ulpi_data_out[5:0]]);
               {rdp, n} <= {1'b1, 32'd0};
            end
            if (n == 1 && cmd == 8'hEF) begin
               oq.push_back(rf[ulpi_data_out]);
               {rdp, n} <= {1'b1, 32'd0};
            end
            if (n == 1 && cmd[7:6] == 2'b10 && cmd[5:0] != 6'h2F) begin
               rf[cmd[5:0]] <= ulpi_data_out;
            end
            if (n == 1 && cmd == 8'hAF) adr <= ulpi_data_out;
            if (n == 2 && cmd == 8'hAF) rf[adr] <= ulpi_data_out;
         end
      end
   end
endmodule

// [ulpx_link_test.sv]
`timescale 1ns/1ps
module ulpx_link_test
   import ulpx_pkg::*;
;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = 3'b010;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata, junk;
   logic        hready, hreadyout, hresp, dir, nxt, oe, stp, got, id_level;
   logic [7:0]  din, dout, got_byte;
   logic [1:0]  line_state, vbus_state, rx_event;
   logic [1:0]  line = 2'b00, vbus = 2'b00, evt = 2'b00;
   logic        id_pin = 1'b0, alt_ev = 1'b0;
   logic [2:0]  lag = 3'd0;
   logic [7:0]  exp_q [$];
   int          fails = 0, samples_checked = 0;
   assign hready = hreadyout;
   always #12.5 clk = ~clk;
   ulpx_link #(.CNT_W(8)) u_dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ulpi_dir(dir), .ulpi_nxt(nxt),
      .ulpi_data_in(din), .ulpi_data_out(dout), .ulpi_data_oe(oe), .ulpi_stp(stp),
      .line_state(line_state), .vbus_state(vbus_state), .rx_event(rx_event), .id_level(id_level));
   ulpx_dev_model u_dev (.clk(clk), .ulpi_data_out(dout), .ulpi_data_oe(oe), .ulpi_stp(stp),
      .line(line), .vbus(vbus), .evt(evt), .id_pin(id_pin), .alt_ev(alt_ev), .lag(lag),
      .ulpi_dir(dir), .ulpi_nxt(nxt), .ulpi_data_in(din), .got(got), .got_byte(got_byte));
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge clk);
      {hsel, htrans, hwrite} <= {1'b1, 2'b10, wr};
      haddr <= {24'h00_0000, a};
      do @(posedge clk); while (hready !== 1'b1);
      {hsel, htrans} <= 3'b000;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic wait_done(output logic [31:0] s);
      int k;
      k = 0;
      do begin ahb(1'b0, ULPX_OFS_STATUS, 32'h0, s); k++; end
      while (s[ULPX_ST_DONE_BIT] !== 1'b1 && k < 100);
      ahb(1'b1, ULPX_OFS_STATUS, 32'h0000_0002, junk);
   endtask
   // Each byte the device accepts is matched against the oldest expected byte.
   always @(posedge clk) begin
      if (got === 1'b1) begin
         if (exp_q.size() == 0) chk("extra bus byte", 32'h0, {24'h0, got_byte});
         else chk("bus byte", exp_q.pop_front(), got_byte);
      end
   end
   initial begin
      repeat (40000) @(posedge clk);
      fails++;
      complete_run();
   end
   initial begin
      logic [31:0] s;
      logic [7:0]  cb, a8, wd, b, cnt;
      logic [7:0]  ws [8];
      logic [5:0]  a6;
      logic [3:0]  p;
      logic [2:0]  kd;
      logic [2:0]  ks [7];
      ks = '{3'd3, 3'd5, 3'd4, 3'd6, 3'd1, 3'd2, 3'd0};
      cnt = 8'h00;
      b = 8'h00;
      void'($urandom(32'h7d50_4db1));
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      for (int l = 0; l < 2; l++) begin
         lag <= 3'(3 * l);
         a6 = 6'($urandom % 47);
         a8 = 8'($urandom % 128) | 8'h01;
         p  = 4'(1 + $urandom % 15);
         for (int i = 0; i < 7; i++) begin
            kd = ks[i];
            case (kd)
               3'd1: cb = 8'h40;
               3'd2: cb = {4'h4, p};
               3'd3: cb = {2'b10, a6};
               3'd4: cb = 8'hAF;
               3'd5: cb = {2'b11, a6};
               3'd6: cb = 8'hEF;
               default: cb = 8'h00;
            endcase
            if (kd != 3'd0) exp_q.push_back(cb);
            if (kd == 3'd4 || kd == 3'd6) exp_q.push_back(a8);
            wd = ~((kd == 3'd4) ? a8 : cb);
            ws[kd] = wd;
            if (kd != 3'd0 && kd < 3'd5) begin
               exp_q.push_back(wd);
               ahb(1'b1, ULPX_OFS_TXDATA, {23'h0, 1'b1, wd}, junk);
            end
            ahb(1'b1, ULPX_OFS_CMD, {12'h0, p, (kd == 3'd4 || kd == 3'd6) ? a8 : {2'b00, a6},
               5'h00, kd}, junk);
            wait_done(s);
            chk("done", 32'h1, s[ULPX_ST_DONE_BIT]);
            chk("busy", 32'h0, s[ULPX_ST_BUSY_BIT]);
            chk("abort", 32'h0, s[ULPX_ST_ABORT_BIT]);
            if (kd > 3'd4) chk("read byte", ws[kd - 3'd2], s[15:8]);
         end
         $display("test commands with lag %0d done", 3 * l);
      end
      for (int i = 0; i < 2; i++) begin
         ahb(1'b1, ULPX_OFS_CMD, (i == 0) ? 32'h0000_0007 : 32'h0000_2F03, junk);
         repeat (20) @(posedge clk);
         ahb(1'b0, ULPX_OFS_STATUS, 32'h0, s);
         chk("refused done", 32'h0, s[ULPX_ST_DONE_BIT]);
      end
      ahb(1'b0, 8'h10, 32'h0, s);
      chk("unmapped read", 32'h0, s);
      $display("test refusals done");
      for (int j = 0; j < 6; j++) begin
         cb = 8'($urandom) & 8'h7F;
         if (cb != b) cnt++;
         b = cb;
         {id_pin, evt, vbus, line} <= b[6:0];
         if (j % 2 == 1) begin
            @(posedge clk);
            b[1:0] = ~b[1:0];
            line <= b[1:0];
            cnt++;
         end
         repeat (30) @(posedge clk);
         ahb(1'b0, ULPX_OFS_RXCMD, 32'h0, s);
         chk("rxcmd byte", b, s[7:0]);
         chk("rxcmd count", cnt, s[15:8]);
         chk("fields", b[6:0], {id_level, rx_event, vbus_state, line_state});
      end
      alt_ev <= 1'b1;
      repeat (30) @(posedge clk);
      ahb(1'b0, ULPX_OFS_STATUS, 32'h0, s);
      chk("alternate set", 32'h1, s[ULPX_ST_ALT_BIT]);
      alt_ev <= 1'b0;
      ahb(1'b1, ULPX_OFS_STATUS, 32'h0000_0004, junk);
      repeat (30) @(posedge clk);
      ahb(1'b0, ULPX_OFS_STATUS, 32'h0, s);
      chk("alternate clear", 32'h0, s[ULPX_ST_ALT_BIT]);
      chk("bytes left", 32'h0, exp_q.size());
      $display("test status done");
      complete_run();
   end
endmodule
